// ---- i2c_slave_pkg.sv ----
// Constants and state encodings for the I2C slave pin and clock-hold block.
// Assumes one system clock domain and the bus clock as a second domain.
// What this block does
// - Bus pins are only ever pulled low (open drain) and only when the port is enabled with both pin directions set to input.
// - The block drives the data pin itself for acknowledge bits and for the bytes it transmits as a slave.
// - With the clock-release bit low the block holds the bus clock low only after it has seen that clock low.
// - The bus clock stays held until software sets the clock-release bit, after which it rises once every device lets go.
// - In sleep the port keeps receiving and wakes the processor on an address match or a finished byte if its interrupt is enabled.
// - The shift register is internal; software sees bytes only through the transfer buffer.
// - Data is sampled on the rising bus clock edge and driven data changes only after the falling edge.
// - Seven- and ten-bit addressing with masking are supported, and the general call address is never answered.
package i2c_slave_pkg;

  // ==========================================================
  // Bit positions within a byte frame
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic [3:0] CNT_RESET = 4'h0;

  // ==========================================================
  // Addressing constants and reset values
  localparam logic [4:0] TEN_BIT_PREFIX = 5'h1E;
  localparam logic [6:0] GENERAL_CALL = 7'h00;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [2:0] SYNC_RESET = 3'h7;
  localparam logic [2:0] TGL_SYNC_RESET = 3'h0;

  // ==========================================================
  // Frame states, one-hot
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_ADDR = 6'h02,
    ST_ADDR2 = 6'h04,
    ST_RX = 6'h08,
    ST_TX = 6'h10,
    ST_IGNORE = 6'h20
  } frame_state_type;

endpackage : i2c_slave_pkg

// ---- i2c_slave_pin_clock_hold.sv ----
// I2C slave core: pin control, acknowledge and transmit drive, clock hold,
// address matching and sleep wake-up.
// Assumes scl_clk_in is wired to the same bus clock line as scl_in, and
// external pull-ups on both lines.
`timescale 1ns/1ps
`default_nettype none
module i2c_slave_pin_clock_hold
  import i2c_slave_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic scl_clk_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic scl_oe_n_out,
  output logic sda_out,
  output logic sda_oe_n_out,
  input wire logic port_enable_in,
  input wire logic pin_direction_scl_in,
  input wire logic pin_direction_sda_in,
  input wire logic clock_release_in,
  input wire logic ten_bit_mode_in,
  input wire logic [9:0] own_address_in,
  input wire logic [9:0] address_mask_in,
  input wire logic tx_load_in,
  input wire logic [7:0] tx_data_in,
  input wire logic sleep_in,
  input wire logic port_irq_enable_in,
  output logic [7:0] transfer_buffer_out,
  output logic byte_done_out,
  output logic addr_match_out,
  output logic read_mode_out,
  output logic wake_out
);

  // ==========================================================
  // Link domain: capture on the rising bus clock edge
  logic [7:0] serial_shift_register;
  logic link_tgl;
  logic [7:0] next_serial_shift_register;
  logic next_link_tgl;

  // Each rising edge shifts one data bit in and flips the toggle.
  always_comb begin
    next_serial_shift_register = {serial_shift_register[6:0], sda_in};
    next_link_tgl = ~link_tgl;
  end

  // The bus clock stops between frames, so the reset here is applied
  // without that clock; it only ever loads constants.
  always_ff @(posedge scl_clk_in or posedge rst_in) begin
    if (rst_in) begin
      serial_shift_register <= BYTE_RESET;
      link_tgl <= 1'b0;
    end else begin
      serial_shift_register <= next_serial_shift_register;
      link_tgl <= next_link_tgl;
    end
  end

  // ==========================================================
  // Pin and toggle synchronisers
  logic [2:0] scl_s, sda_s, tgl_s;
  logic scl_f, sda_f, scl_fp, sda_fp, next_scl_f, next_sda_f;
  logic [2:0] next_scl_s, next_sda_s, next_tgl_s;

  // A pin level counts only when the second and third stage agree.
  always_comb begin
    next_scl_s = {scl_s[1:0], scl_in};
    next_sda_s = {sda_s[1:0], sda_in};
    next_tgl_s = {tgl_s[1:0], link_tgl};
    next_scl_f = (scl_s[1] == scl_s[2]) ? scl_s[2] : scl_f;
    next_sda_f = (sda_s[1] == sda_s[2]) ? sda_s[2] : sda_f;
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      scl_s <= SYNC_RESET;
      sda_s <= SYNC_RESET;
      tgl_s <= TGL_SYNC_RESET;
      scl_f <= 1'b1;
      sda_f <= 1'b1;
      scl_fp <= 1'b1;
      sda_fp <= 1'b1;
    end else begin
      scl_s <= next_scl_s;
      sda_s <= next_sda_s;
      tgl_s <= next_tgl_s;
      scl_f <= next_scl_f;
      sda_f <= next_sda_f;
      scl_fp <= scl_f;
      sda_fp <= sda_f;
    end
  end

  // Bus events seen in the system domain.
  logic rise_ev, fall_ev, start_ev, stop_ev, pins_ok;
  assign rise_ev = tgl_s[1] ^ tgl_s[2];
  assign fall_ev = scl_fp & ~scl_f;
  assign start_ev = scl_f & scl_fp & sda_fp & ~sda_f;
  assign stop_ev = scl_f & scl_fp & ~sda_fp & sda_f;
  assign pins_ok = port_enable_in & pin_direction_scl_in
                   & pin_direction_sda_in;

  // ==========================================================
  // Frame control
  frame_state_type state, next_state;
  logic [3:0] cnt, next_cnt;
  logic ack_pend, next_ack_pend;
  logic hi_match, next_hi_match;
  logic sda_low, next_sda_low;
  logic scl_hold, next_scl_hold;
  logic [7:0] tx_buf, next_tx_buf;
  logic [7:0] xfer_buf, next_xfer_buf;
  logic next_byte_done, next_addr_match, next_read_mode, next_wake;
  logic [7:0] word;
  logic match7, match_hi, match_lo;

  assign word = serial_shift_register;
  // Mask bit set means the address bit is compared.
  assign match7 = (((word[7:1] ^ own_address_in[6:0])
                   & address_mask_in[6:0]) == 7'h00)
                  && (word[7:1] != GENERAL_CALL);
  assign match_hi = (word[7:3] == TEN_BIT_PREFIX)
                    && (((word[2:1] ^ own_address_in[9:8])
                    & address_mask_in[9:8]) == 2'h0);
  assign match_lo = ((word ^ own_address_in[7:0])
                    & address_mask_in[7:0]) == 8'h00;

  // Next-state logic for the frame; the word is stable until the next rising bus clock edge
  // after a toggle arrives, so reading it here is a safe crossing.
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_ack_pend = ack_pend;
    next_hi_match = hi_match;
    next_sda_low = sda_low;
    next_tx_buf = tx_buf;
    next_xfer_buf = tx_load_in ? tx_data_in : xfer_buf;
    next_byte_done = 1'b0;
    next_addr_match = 1'b0;
    next_read_mode = read_mode_out;
    if (!pins_ok || stop_ev) begin
      next_state = ST_IDLE;
      next_hi_match = 1'b0;
      next_ack_pend = 1'b0;
      next_sda_low = 1'b0;
    end else if (start_ev) begin
      next_state = ST_ADDR;
      next_cnt = CNT_RESET;
      next_ack_pend = 1'b0;
      next_sda_low = 1'b0;
    end else if (rise_ev && state != ST_IDLE && state != ST_IGNORE) begin
      if (cnt == BIT_ACK) begin
        next_cnt = CNT_RESET;
        next_ack_pend = 1'b0;
        if (state == ST_TX && !ack_pend) begin
          if (word[0]) begin
            next_state = ST_IGNORE;
          end else begin
            next_tx_buf = xfer_buf;
          end
        end
      end else begin
        next_cnt = cnt + 4'h1;
        if (cnt == BIT_LAST) begin
          case (state)
            ST_ADDR: begin
              if (ten_bit_mode_in) begin
                if (match_hi && !word[0]) begin
                  next_ack_pend = 1'b1;
                  next_state = ST_ADDR2;
                end else if (match_hi && hi_match) begin
                  next_ack_pend = 1'b1;
                  next_addr_match = 1'b1;
                  next_read_mode = 1'b1;
                  next_state = ST_TX;
                  next_tx_buf = xfer_buf;
                end else begin
                  next_state = ST_IGNORE;
                end
              end else if (match7) begin
                next_ack_pend = 1'b1;
                next_addr_match = 1'b1;
                next_read_mode = word[0];
                next_state = word[0] ? ST_TX : ST_RX;
                next_tx_buf = xfer_buf;
              end else begin
                next_state = ST_IGNORE;
              end
            end
            ST_ADDR2: begin
              if (match_lo) begin
                next_ack_pend = 1'b1;
                next_hi_match = 1'b1;
                next_addr_match = 1'b1;
                next_read_mode = 1'b0;
                next_state = ST_RX;
              end else begin
                next_state = ST_IGNORE;
              end
            end
            ST_RX: begin
              next_xfer_buf = word;
              next_byte_done = 1'b1;
              next_ack_pend = 1'b1;
            end
            ST_TX: begin
              next_byte_done = 1'b1;
            end
            default: begin
              next_state = ST_IGNORE;
            end
          endcase
        end
      end
    end else if (fall_ev) begin
      // Drive changes only while the bus clock is low.
      next_sda_low = ((cnt == BIT_ACK) && ack_pend)
                     || ((state == ST_TX) && (cnt < BIT_ACK)
                     && !tx_buf[3'(BIT_LAST - cnt)]);
    end
    // Hold once the clock is seen low, let go on release.
    next_scl_hold = pins_ok && !clock_release_in
                    && (scl_hold || !scl_f);
    next_wake = sleep_in && (wake_out || (port_irq_enable_in
                && (next_byte_done || next_addr_match)));
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      state <= ST_IDLE;
      cnt <= CNT_RESET;
      ack_pend <= 1'b0;
      hi_match <= 1'b0;
      sda_low <= 1'b0;
      scl_hold <= 1'b0;
      tx_buf <= BYTE_RESET;
      xfer_buf <= BYTE_RESET;
      byte_done_out <= 1'b0;
      addr_match_out <= 1'b0;
      read_mode_out <= 1'b0;
      wake_out <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      ack_pend <= next_ack_pend;
      hi_match <= next_hi_match;
      sda_low <= next_sda_low;
      scl_hold <= next_scl_hold;
      tx_buf <= next_tx_buf;
      xfer_buf <= next_xfer_buf;
      byte_done_out <= next_byte_done;
      addr_match_out <= next_addr_match;
      read_mode_out <= next_read_mode;
      wake_out <= next_wake;
    end
  end

  // ==========================================================
  // Open-drain pins: the line is only ever pulled low, never driven high.
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe_n_out = ~(pins_ok & scl_hold);
  assign sda_oe_n_out = ~(pins_ok & sda_low);
  assign transfer_buffer_out = xfer_buf;

  // ==========================================================
  // Checks
  property p_pins_idle;
    @(posedge sys_clk_in) disable iff (rst_in)
      !pins_ok |-> (scl_oe_n_out && sda_oe_n_out && !scl_out && !sda_out)
      ##1 (!scl_hold && !sda_low);
  endproperty
  a_pins_idle: assert property (p_pins_idle)
    else $error("Pin pulled while port disabled.");

  property p_ack_drive;
    @(posedge sys_clk_in) disable iff (rst_in)
      (fall_ev && pins_ok && !rise_ev && !start_ev && !stop_ev
       && cnt == BIT_ACK && ack_pend) |=> !sda_oe_n_out;
  endproperty
  a_ack_drive: assert property (p_ack_drive)
    else $error("Acknowledge not driven after falling clock.");

  property p_hold_needs_low;
    @(posedge sys_clk_in) disable iff (rst_in)
      $rose(scl_hold) |-> !$past(scl_f);
  endproperty
  a_hold_needs_low: assert property (p_hold_needs_low)
    else $error("Clock hold began while clock high.");

  property p_hold_keeps;
    @(posedge sys_clk_in) disable iff (rst_in)
      (scl_hold && pins_ok && !clock_release_in) |=> scl_hold;
  endproperty
  a_hold_keeps: assert property (p_hold_keeps)
    else $error("Clock hold dropped without release.");

  property p_hold_release;
    @(posedge sys_clk_in) disable iff (rst_in)
      clock_release_in |=> (!scl_hold && scl_oe_n_out);
  endproperty
  a_hold_release: assert property (p_hold_release)
    else $error("Clock still held after release.");

  property p_wake;
    @(posedge sys_clk_in) disable iff (rst_in)
      ($past(sleep_in && port_irq_enable_in) && byte_done_out)
      |-> (wake_out ##1 (wake_out || !$past(sleep_in)));
  endproperty
  a_wake: assert property (p_wake)
    else $error("No wake on finished byte in sleep.");

  property p_rx_buffer;
    @(posedge sys_clk_in) disable iff (rst_in)
      (byte_done_out && !read_mode_out && !$past(tx_load_in))
      |-> transfer_buffer_out == $past(serial_shift_register);
  endproperty
  a_rx_buffer: assert property (p_rx_buffer)
    else $error("Received byte not in transfer buffer.");

  property p_drive_on_fall;
    @(posedge sys_clk_in) disable iff (rst_in)
      $rose(sda_low) |-> $past(fall_ev);
  endproperty
  a_drive_on_fall: assert property (p_drive_on_fall)
    else $error("Data drive changed outside clock low.");

  property p_no_general_call;
    @(posedge sys_clk_in) disable iff (rst_in)
      (rise_ev && pins_ok && !start_ev && !stop_ev && state == ST_ADDR
       && cnt == BIT_LAST && !ten_bit_mode_in && word[7:1] == GENERAL_CALL)
      |=> (state == ST_IGNORE && !ack_pend && !addr_match_out);
  endproperty
  a_no_general_call: assert property (p_no_general_call)
    else $error("General call answered.");

endmodule : i2c_slave_pin_clock_hold
`default_nettype wire

// ---- i2c_master_model.sv ----
// Behavioural I2C bus master that drives the bus for the slave bench.
// Assumes the bench resolves both open-drain lines with pull-ups.
`timescale 1ns/1ps
`default_nettype none
module i2c_master_model (
  input wire logic scl_in,
  input wire logic sda_in,
  output logic scl_low_out,
  output logic sda_low_out
);
  // ==========================================================
  // Bus phases
  // Phases of 60 ns keep data changes well clear of the clock edges.
  initial begin
    scl_low_out = 1'b0;
    sda_low_out = 1'b0;
  end

  // Let the clock go and wait, bounded, while another device holds it.
  task automatic rise();
    int n;
    scl_low_out = 1'b0;
    for (n = 0; n < 20000 && scl_in !== 1'b1; n++) #1;
    #60;
  endtask : rise

  // A start from idle or a repeated start from a low clock.
  task automatic start();
    #60 sda_low_out = 1'b0;
    #60 rise();
    #60 sda_low_out = 1'b1;
    #120 scl_low_out = 1'b1;
  endtask : start

  // A stop ends the frame with both lines released.
  task automatic stop();
    #60 sda_low_out = 1'b1;
    #60 rise();
    #60 sda_low_out = 1'b0;
    #120;
  endtask : stop

  // Data only changes while the clock is low.
  task automatic clk_bit(input logic b, output logic r);
    #60 sda_low_out = !b;
    #60 rise();
    r = sda_in;
    #60 scl_low_out = 1'b1;
  endtask : clk_bit

  // Eight bits out, then the slave's acknowledge is read back.
  task automatic byte_w(input logic [7:0] d, output logic ack_n);
    for (int i = 7; i >= 0; i--) clk_bit(d[i], ack_n);
    clk_bit(1'b1, ack_n);
  endtask : byte_w

  // Eight bits in, then our acknowledge or refusal.
  task automatic byte_r(input logic nack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) clk_bit(1'b1, d[i]);
    clk_bit(nack, r);
  endtask : byte_r
endmodule : i2c_master_model
`default_nettype wire

// ---- testbench.sv ----
// Self-checking bench for the I2C slave pin and clock-hold block.
// Assumes the master model owns the bus and idle lines float high.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic sys_clk_in, rst_in, port_enable, dir_scl, dir_sda, clock_release;
  logic ten_bit, tx_load, sleep, irq_en, a0, a1;
  logic [9:0] own_address, address_mask;
  logic [7:0] tx_data, transfer_buffer, rd;
  logic scl_o, scl_oe_n, sda_o, sda_oe_n, byte_done, addr_match;
  logic read_mode, wake, m_scl_low, m_sda_low, scl_w, sda_w;
  int err_total = 0, total_checks = 0, n_done = 0, n_match = 0;
  int n_drive = 0, cyc = 0;
  logic [7:0] hdrs [3] = '{8'hB6, 8'h00, 8'hB6};
  logic [9:0] masks [3] = '{10'h3FF, 10'h000, 10'h3FE};
  logic acks [3] = '{1'b1, 1'b1, 1'b0};

  // ==========================================================
  // Bus wiring
  // Any party pulling low wins; the pull-ups give a high otherwise.
  assign scl_w = !(m_scl_low || (!scl_oe_n && !scl_o));
  assign sda_w = !(m_sda_low || (!sda_oe_n && !sda_o));

  i2c_slave_pin_clock_hold i_dut (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
    .scl_clk_in(scl_w), .scl_in(scl_w), .sda_in(sda_w), .scl_out(scl_o),
    .scl_oe_n_out(scl_oe_n), .sda_out(sda_o), .sda_oe_n_out(sda_oe_n),
    .port_enable_in(port_enable), .pin_direction_scl_in(dir_scl),
    .pin_direction_sda_in(dir_sda), .clock_release_in(clock_release),
    .ten_bit_mode_in(ten_bit), .own_address_in(own_address),
    .address_mask_in(address_mask), .tx_load_in(tx_load),
    .tx_data_in(tx_data), .sleep_in(sleep), .port_irq_enable_in(irq_en),
    .transfer_buffer_out(transfer_buffer), .byte_done_out(byte_done),
    .addr_match_out(addr_match), .read_mode_out(read_mode),
    .wake_out(wake));

  i2c_master_model i_master (.scl_in(scl_w), .sda_in(sda_w),
    .scl_low_out(m_scl_low), .sda_low_out(m_sda_low));

  // ==========================================================
  // Clock, event counting and hang limit
  initial begin
    sys_clk_in = 1'b0;
    forever #4 sys_clk_in = ~sys_clk_in;
  end

  // One-cycle pulses are counted here so no test can miss them.
  always @(posedge sys_clk_in) begin
    cyc++;
    if (byte_done === 1'b1) n_done++;
    if (addr_match === 1'b1) n_match++;
    if (sda_oe_n === 1'b0) n_drive++;
    if (cyc == 40000) begin
      err_total++;
      summarize();
    end
  end

  // ==========================================================
  // Tasks
  task automatic chk(input logic [9:0] got, input logic [9:0] exp,
                     input string what);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk

  // Ends a test on a falling edge and clears the event counts.
  task automatic done(input string name);
    @(negedge sys_clk_in);
    $display("test %s finished", name);
    n_done = 0;
    n_match = 0;
    n_drive = 0;
  endtask : done

  task automatic frame(input logic [7:0] hdr, input logic [7:0] dat);
    i_master.start();
    i_master.byte_w(hdr, a0);
    i_master.byte_w(dat, a1);
    i_master.stop();
  endtask : frame

  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : summarize

  // ==========================================================
  // Test sequence
  initial begin
    rst_in = 1'b1;
    port_enable = 1'b1;
    dir_scl = 1'b1;
    dir_sda = 1'b1;
    clock_release = 1'b1;
    ten_bit = 1'b0;
    own_address = 10'h05A;
    address_mask = 10'h3FF;
    tx_load = 1'b0;
    tx_data = 8'h00;
    sleep = 1'b0;
    irq_en = 1'b0;
    repeat (6) @(negedge sys_clk_in);
    rst_in = 1'b0;
    repeat (6) @(negedge sys_clk_in);
    chk(scl_oe_n, 1'b1, "scl idle");
    chk(sda_oe_n, 1'b1, "sda idle");
    chk(transfer_buffer, 8'h00, "buffer reset");
    chk({scl_o, sda_o}, 2'h0, "open drain");
    frame(8'hB4, 8'hC3);
    chk(a0, 1'b0, "addr ack");
    chk(a1, 1'b0, "data ack");
    chk(n_match, 1, "match count");
    chk(n_done, 1, "byte count");
    chk(transfer_buffer, 8'hC3, "rx byte");
    done("write7");
    // Mismatch, general call under an all-open mask, and a masked match.
    for (int k = 0; k < 3; k++) begin
      address_mask = masks[k];
      frame(hdrs[k], 8'h11);
      chk(a0, acks[k], "refusal");
      chk(n_match, !acks[k], "refused match");
      done("address");
    end
    address_mask = 10'h3FF;
    tx_data = 8'hA5;
    tx_load = 1'b1;
    @(negedge sys_clk_in);
    tx_load = 1'b0;
    i_master.start();
    i_master.byte_w(8'hB5, a0);
    chk(a0, 1'b0, "read addr ack");
    chk(read_mode, 1'b1, "read mode");
    i_master.byte_r(1'b1, rd);
    i_master.stop();
    chk(rd, 8'hA5, "tx byte");
    chk(n_done, 1, "tx count");
    done("read7");
    ten_bit = 1'b1;
    own_address = 10'h2B7;
    i_master.start();
    i_master.byte_w(8'hF4, a0);
    i_master.byte_w(8'hB7, a1);
    chk(a1, 1'b0, "ten bit ack");
    chk(n_match, 1, "ten bit match");
    i_master.byte_w(8'h3C, a0);
    chk(transfer_buffer, 8'h3C, "ten bit rx");
    // Repeated start into a read. The byte sent first is the one received
    // above; a load made during it is sent after the master's acknowledge.
    i_master.start();
    i_master.byte_w(8'hF5, a0);
    chk(a0, 1'b0, "ten bit read ack");
    fork
      i_master.byte_r(1'b0, rd);
      begin
        @(negedge sys_clk_in);
        tx_data = 8'h96;
        tx_load = 1'b1;
        @(negedge sys_clk_in);
        tx_load = 1'b0;
      end
    join
    chk(rd, 8'h3C, "ten bit tx");
    i_master.byte_r(1'b1, rd);
    i_master.stop();
    chk(rd, 8'h96, "tx reload");
    chk(n_match, 2, "ten bit read match");
    chk(n_done, 3, "ten bit count");
    done("write10");
    ten_bit = 1'b0;
    own_address = 10'h05A;
    clock_release = 1'b0;
    repeat (10) @(negedge sys_clk_in);
    chk(scl_oe_n, 1'b1, "no hold while high");
    fork
      frame(8'hB4, 8'h5E);
      begin
        #800;
        chk(scl_w, 1'b0, "clock held");
        chk(scl_oe_n, 1'b0, "hold drive");
        @(negedge sys_clk_in);
        clock_release = 1'b1;
        repeat (3) @(negedge sys_clk_in);
        chk(scl_w, 1'b1, "clock freed");
      end
    join
    chk(transfer_buffer, 8'h5E, "held rx");
    done("hold");
    sleep = 1'b1;
    for (int k = 0; k < 2; k++) begin
      irq_en = k[0];
      frame(8'hB4, 8'h69 + k[7:0]);
      chk(wake, k[0], "wake");
      chk(transfer_buffer, 8'h69 + k[7:0], "rx asleep");
      done("sleep");
    end
    sleep = 1'b0;
    repeat (2) @(negedge sys_clk_in);
    chk(wake, 1'b0, "wake cleared");
    // Port off, then the data pin not set as input: the bus stays passive.
    for (int k = 0; k < 2; k++) begin
      port_enable = k[0];
      dir_sda = !k[0];
      frame(8'hB4, 8'h22);
      chk(a0, 1'b1, "no ack when off");
      chk(n_drive, 0, "no drive when off");
      done("off");
    end
    summarize();
  end
endmodule : testbench
`default_nettype wire
